// >>> design/dpcs_clock_select.sv
/*
 * Clock sourcing for a dual speed physical layer: 25 MHz output from
 * the 50 MHz oscillator with glitch-free gating, reference input
 * monitoring, crystal or internal 20 MHz timing source selection, and
 * the 10 Mb/s transmit pair drivers.
 * Assumes every clock pin is slow enough relative to clk to be seen as
 * a sampled level; a behavioural stand-in for the analog clock tree.
 */
// Contract
// RULE1: Divide 50 MHz oscillator to make 25 MHz.
// RULE2: Disable input stops the 25 MHz output.
// RULE3: Device resets leave 25 MHz output alone.
// RULE4: Accept 25 MHz reference on reference input.
// RULE5: Crystal clock times 10 Mb/s and negotiation.
// RULE6: Crystal pin high selects internal 20 MHz.
// RULE7: Send 10 Mb/s data on unshielded pair.
// RULE8: Send 10 Mb/s data on shielded pair.
// RULE9: Gate 25 MHz output only while low.
module dpcs_clock_select (
    input wire logic clk,
    input wire logic por_srst,
    input wire logic srst,
    input wire logic soft_srst,
    input wire logic osc_clk_50_in,
    input wire logic ref_clk_in,
    input wire logic xtal_in,
    input wire logic [1:0] tp_rx_pair,
    input wire logic clk_out_disable,
    input wire logic tx10_en,
    input wire logic tx10_data,
    input wire logic link_pulse,
    output logic clk_out_25,
    output logic xtal_out,
    output logic ref_clk_tick,
    output logic tim_20_tick,
    output logic use_internal_20,
    output logic rx10_data,
    output logic [1:0] utp_tx_pair,
    output logic [1:0] stp_tx_pair
);
    import dpcs_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [4:0] pin_raw;
    logic [4:0] pin_s;
    logic osc_s, ref_s, xtal_s;
    logic [1:0] rx_s;

    assign pin_raw = {tp_rx_pair, xtal_in, ref_clk_in, osc_clk_50_in};
    assign osc_s = pin_s[0];
    assign ref_s = pin_s[1];
    assign xtal_s = pin_s[2];
    assign rx_s = pin_s[4:3];

    // Power-on reset only, so the 25 MHz path keeps running
    dpcs_sync #(.W(5)) u_sync (
        .clk(clk),
        .srst(por_srst),
        .d(pin_raw),
        .q(pin_s)
    );

    // Rising edge test shared by every sampled clock
    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // 25 MHz output: divide by two, gate at low phase

    logic osc_prev;
    logic div25;
    logic gate_on;
    logic osc_rise;
    logic next_div25;
    logic next_gate_on;

    assign osc_rise = rise(osc_s, osc_prev);
    assign next_div25 = osc_rise ? ~div25 : div25; // [RULE1]
    // Gate changes only while the divided clock sits low   [RULE9]
    assign next_gate_on = (next_div25 == 1'b0) ? ~clk_out_disable
                                               : gate_on; // [RULE2]

    // Runs on power-on reset alone; device resets are ignored here
    always_ff @(posedge clk) begin
        if (por_srst) begin // [RULE3]
            osc_prev <= 1'b0;
            div25 <= 1'b0;
            gate_on <= 1'b1;
            clk_out_25 <= 1'b0;
        end else begin
            osc_prev <= osc_s;
            div25 <= next_div25;
            gate_on <= next_gate_on;
            clk_out_25 <= next_div25 & next_gate_on; // [RULE2]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reference input monitor

    logic ref_prev;
    logic dev_rst;

    // Either device reset clears the device side
    assign dev_rst = srst | soft_srst | por_srst;

    // The reference may be our own output looped back, so no assumption
    // about its phase against the oscillator is made
    always_ff @(posedge clk) begin
        if (dev_rst) begin
            // Track the pin in reset so release shows no false edge
            ref_prev <= ref_s;
            ref_clk_tick <= 1'b0;
        end else begin
            ref_prev <= ref_s;
            ref_clk_tick <= rise(ref_s, ref_prev); // [RULE4]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Internal 20 MHz: oscillator half periods counted by five

    logic osc_edge;
    logic [2:0] half_cnt;
    logic int20;
    logic half_wrap;
    logic [2:0] next_half_cnt;
    // Timing source, needed here to hold the divider while unused
    dpcs_src_t src, next_src;

    assign osc_edge = osc_s ^ osc_prev;
    assign half_wrap = osc_edge && (half_cnt == DIV_HALF_EDGES - 3'h1);
    assign next_half_cnt = half_wrap ? 3'h0
                         : osc_edge ? half_cnt + 3'h1 : half_cnt;

    // Divider only runs once the strap selected it   [RULE6]
    always_ff @(posedge clk) begin
        if (dev_rst || src != SRC_INT) begin
            half_cnt <= 3'h0;
            int20 <= 1'b0;
        end else begin
            half_cnt <= next_half_cnt;
            // High for two of every five edges: one rise per 2.5 periods
            int20 <= (next_half_cnt < (DIV_HALF_EDGES >> 1)); // [RULE6]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Strap detect and timing source selection

    logic [STRAP_CW-1:0] high_cnt;
    logic [STRAP_CW-1:0] next_high_cnt;
    logic strap_seen;
    logic tim_prev;
    logic tim_sel;

    // A running crystal toggles and keeps restarting the count
    assign strap_seen = (high_cnt == STRAP_CW'(STRAP_CYCLES));
    assign next_high_cnt = !xtal_s ? '0
                         : strap_seen ? high_cnt : high_cnt + 1'b1;

    // Strap is latched: once internal, stays until a device reset
    always_comb begin
        case (src)
            SRC_XTAL: next_src = strap_seen ? SRC_INT : SRC_XTAL; // [RULE6]
            SRC_INT: next_src = SRC_INT;
            default: next_src = SRC_XTAL;
        endcase
    end

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            src <= SRC_XTAL;
            high_cnt <= '0;
        end else begin
            src <= next_src;
            high_cnt <= next_high_cnt;
        end
    end

    // Selected timing clock for 10 Mb/s and auto-negotiation
    assign tim_sel = (src == SRC_INT) ? int20 : xtal_s; // [RULE5] [RULE6]

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            // Follow the source in reset: no false tick at release
            tim_prev <= tim_sel;
            tim_20_tick <= 1'b0;
            use_internal_20 <= 1'b0;
            xtal_out <= 1'b0;
        end else begin
            tim_prev <= tim_sel;
            tim_20_tick <= rise(tim_sel, tim_prev); // [RULE5]
            use_internal_20 <= (next_src == SRC_INT);
            // Crystal feedback only while the crystal is the source
            xtal_out <= (next_src == SRC_XTAL) ? ~xtal_s : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // 10 Mb/s transmit pairs and receive level

    logic tx_active;
    logic tx_bit;
    logic [1:0] next_pair;

    // Link pulses go out even with no frame in progress
    assign tx_active = tx10_en | link_pulse;
    assign tx_bit = tx10_en ? tx10_data : 1'b1;
    // Pair order is {minus, plus}; idle leaves both legs low
    assign next_pair = tx_active ? {~tx_bit, tx_bit} : 2'b00;

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            utp_tx_pair <= 2'b00;
            stp_tx_pair <= 2'b00;
            rx10_data <= 1'b0;
        end else begin
            utp_tx_pair <= next_pair; // [RULE7]
            stp_tx_pair <= next_pair; // [RULE8]
            rx10_data <= rx_s[0] & ~rx_s[1];
        end
    end
endmodule // dpcs_clock_select

// >>> design/dpcs_pkg.sv
/*
 * Constants for the dual speed clock select block: configuration bit
 * position, clock figures, divider ratios and the strap detect time.
 * Assumes a single 10 MHz system clock samples every clock pin.
 */
package dpcs_pkg;
    // Configuration word that holds the output disable bit
    localparam logic [7:0] CFG_REG_ADDR = 8'h17;
    localparam int CFG_CLK25_OFF_BIT = 7;
    // Clock figures in MHz
    localparam int OSC_MHZ = 50;
    localparam int OUT_MHZ = 25;
    localparam int XTAL_MHZ = 20;
    localparam int SYS_MHZ = 10;
    // Oscillator edges, both kinds, per period of the 20 MHz clock:
    // five edges make two and a half oscillator periods
    localparam logic [2:0] DIV_HALF_EDGES = 3'h5;
    // Time the crystal pin must stay high before it counts as strapped
    localparam int STRAP_TIME_NS = 2000;
    localparam int SYS_PERIOD_NS = 1000 / SYS_MHZ;
    localparam int STRAP_CYCLES =
        (STRAP_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int STRAP_CW = $clog2(STRAP_CYCLES + 1);
    // Source of the 10 Mb/s and auto-negotiation timing
    typedef enum logic [1:0] {
        SRC_XTAL = 2'b01,
        SRC_INT = 2'b10
    } dpcs_src_t;
endpackage

// >>> design/dpcs_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of pin levels.
 * Assumes each bit is an independent level; no bus coherence.
 */
module dpcs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // dpcs_sync

// >>> dv/dpcs_chk_sva.sv
/* Port checker for the clock select block.
   Assumes the oscillator half period of two clk cycles from the model. */
module dpcs_chk (
    input wire logic clk,
    input wire logic por_srst,
    input wire logic srst,
    input wire logic soft_srst,
    input wire logic osc_clk_50_in,
    input wire logic ref_clk_in,
    input wire logic xtal_in,
    input wire logic clk_out_disable,
    input wire logic tx10_en,
    input wire logic tx10_data,
    input wire logic link_pulse,
    input wire logic clk_out_25,
    input wire logic ref_clk_tick,
    input wire logic use_internal_20,
    input wire logic [1:0] utp_tx_pair,
    input wire logic [1:0] stp_tx_pair
);
    timeunit 1ns;
    timeprecision 1ns;
    // Any device reset quiets the timing and transmit outputs
    wire dev_rst = por_srst | srst | soft_srst;
    default clocking @(posedge clk); endclocking
    default disable iff (dev_rst);
    div_edge_a: assert property (disable iff (por_srst)
        $changed(clk_out_25) |-> $past(osc_clk_50_in, 3)
        && !$past(osc_clk_50_in, 4)) else $error("out off osc edge");
    pulse_whole_a: assert property (disable iff (por_srst)
        $fell(clk_out_25) |-> $past(clk_out_25, 3))
        else $error("short pulse");
    gate_off_a: assert property (disable iff (por_srst)
        clk_out_disable [*8] |-> !clk_out_25) else $error("not gated");
    ref_tick_a: assert property ($rose(ref_clk_in) |-> ##3 ref_clk_tick)
        else $error("ref tick lost");
    strap_a: assert property ($rose(use_internal_20) |->
        $past(xtal_in, 3) && $past(xtal_in, 20)) else $error("strap");
    tx_data_a: assert property (tx10_en |=>
        utp_tx_pair == {~$past(tx10_data), $past(tx10_data)})
        else $error("tx data");
    tx_link_a: assert property (!tx10_en && link_pulse |=>
        utp_tx_pair == 2'h1) else $error("link pulse");
    pair_same_a: assert property (utp_tx_pair == stp_tx_pair)
        else $error("pairs differ");
endmodule // dpcs_chk
bind dpcs_clock_select dpcs_chk dpcs_chk_i (.clk, .por_srst, .srst,
    .soft_srst, .osc_clk_50_in, .ref_clk_in, .xtal_in, .clk_out_disable,
    .tx10_en, .tx10_data, .link_pulse, .clk_out_25, .ref_clk_tick,
    .use_internal_20, .utp_tx_pair, .stp_tx_pair);

// >>> dv/dpcs_src_model.sv
/* Board clock sources: 50 MHz oscillator, crystal or strap, loop of
   the 25 MHz output. Assumes clk is faster than every source here. */
module dpcs_src_model (
    input wire logic clk,
    input wire logic run,
    input wire logic strap,
    input wire logic clk_out_25,
    output logic osc_clk_50_in,
    output logic xtal_in,
    output logic ref_clk_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // Pull-down holds the oscillator low while it is not running
    initial osc_clk_50_in = 1'b0;
    initial xtal_in = 1'b1;
    always @(negedge clk) begin
        cnt <= cnt + 1;
        osc_clk_50_in <= run & cnt[1];
        xtal_in <= strap | (cnt % 6 < 3); // Pull-up when strapped
    end
    // Reference fed back from the device's own output
    assign ref_clk_in = clk_out_25;
endmodule // dpcs_src_model

// >>> dv/tb.sv
/* Self-checking bench for the clock select block.
   Assumes the source model drives all clock pins. */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, por_srst = 1, srst = 1, soft_srst = 1, run = 0;
    logic strap = 0, clk_out_disable = 0, tx10_en = 0, tx10_data = 0;
    logic link_pulse = 0, osc_clk_50_in, ref_clk_in, xtal_in, clk_out_25;
    logic xtal_out, ref_clk_tick, tim_20_tick, use_internal_20, rx10_data;
    logic [1:0] tp_rx_pair = 2'h0, utp_tx_pair, stp_tx_pair;
    int mismatches = 0, compares = 0, n_out = 0, n_ref = 0, n_tim = 0, b;
    logic prev = 0;
    dpcs_clock_select dpcs_clock_select_i (.clk, .por_srst, .srst,
        .soft_srst, .osc_clk_50_in, .ref_clk_in, .xtal_in, .tp_rx_pair,
        .clk_out_disable, .tx10_en, .tx10_data, .link_pulse, .clk_out_25,
        .xtal_out, .ref_clk_tick, .tim_20_tick, .use_internal_20,
        .rx10_data, .utp_tx_pair, .stp_tx_pair);
    dpcs_src_model dpcs_src_model_i (.clk, .run, .strap, .clk_out_25,
        .osc_clk_50_in, .xtal_in, .ref_clk_in);
    // Clock, then edge counters sampled where outputs are settled
    initial forever #50 clk = ~clk;
    always @(negedge clk) begin
        n_out += int'(clk_out_25 & ~prev);
        prev = clk_out_25;
        n_ref += int'(ref_clk_tick === 1'b1);
        n_tim += int'(tim_20_tick === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("mismatch %0t %s", $time, what);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Wait n falling edges, counting from the snapshot b
    task automatic span(input int n);
        b = n_out;
        repeat (n) @(negedge clk);
    endtask
    task automatic t_tx;
        logic [2:0] v;
        logic [1:0] e;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            {tx10_en, tx10_data, link_pulse} = v;
            tp_rx_pair = v[1:0];
            @(negedge clk);
            e = v[2] ? {~v[1], v[1]} : {1'b0, v[0]};
            check(utp_tx_pair === e, "utp pair");
            check(stp_tx_pair === e, "stp pair");
            // Receive level lags its pins by the synchroniser and a flop
            if (i >= 2) check(rx10_data === ((i - 2) % 4 == 1), "rx");
        end
        {tx10_en, tx10_data, link_pulse} = 3'h0;
    endtask
    task automatic t_div;
        int r;
        r = n_ref;
        span(80);
        check(n_out - b inside {[9:11]}, "25 rate");
        check(n_ref - r inside {[9:11]}, "ref rate");
    endtask
    task automatic t_dis;
        clk_out_disable = 1;
        repeat (10) @(negedge clk);
        span(40);
        check(n_out == b && clk_out_25 === 1'b0, "gated");
        clk_out_disable = 0;
        span(40);
        check(n_out - b >= 4, "regated");
    endtask
    task automatic t_rst;
        for (int k = 0; k < 2; k++) begin
            {srst, soft_srst} = k ? 2'h1 : 2'h2;
            span(40);
            check(n_out - b >= 4, "reset");
            check(utp_tx_pair === 2'h0, "reset pair");
        end
        {srst, soft_srst} = 2'h0;
    endtask
    task automatic t_src;
        b = n_tim;
        repeat (60) @(negedge clk);
        check(use_internal_20 === 1'b0, "xt sel");
        check(n_tim - b inside {[9:11]}, "xt rate");
        strap = 1;
        repeat (40) @(negedge clk);
        b = n_tim;
        repeat (80) @(negedge clk);
        // One rise per five oscillator edges: ten cycles per tick here
        check(use_internal_20 === 1'b1, "i20 sel");
        check(n_tim - b inside {[7:9]}, "i20 rate");
        check(xtal_out === 1'b0, "xtal out");
    endtask
    // Reset for six cycles, then the scenarios in turn
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        {por_srst, srst, soft_srst, run} = 4'h1;
        t_tx();
        t_div();
        t_dis();
        t_rst();
        t_src();
        report_and_stop();
    end
    // Watchdog well past the expected run of about 450 cycles
    initial begin
        repeat (1500) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule // tb
